/* File: rtl/ld_cfg_regs.sv */
// Logical device configuration register bank behind the index/data ports
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module ld_cfg_regs (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       hard_rst,
  input  wire logic       main_por,
  input  wire logic       sby_por,
  input  wire logic       cfg_wr,
  input  wire logic       idx_wr,
  input  wire logic       dat_wr,
  input  wire logic       dat_rd,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata_r,
  output logic            in_cfg_r,
  output logic      [7:0] devnum_r,
  output logic            soft_rst_r,
  output logic      [7:0] ser1_mode_r,
  output logic      [7:0] ser2_mode_r,
  output logic      [7:0] kbd_sel_r,
  output logic      [7:0] midi_base_hi_r,
  output logic      [7:0] midi_base_lo_r
);
  localparam int NREG = 21;
  localparam logic [3:0] EV_ALL  = 4'hF;
  localparam logic [3:0] EV_HWP  = 4'h7;
  localparam logic [3:0] EV_SBY  = 4'h4;
  // Table slots that are read out by name
  localparam logic [4:0] SLOT_SER1_MODE = 5'h01;
  localparam logic [4:0] SLOT_SER2_MODE = 5'h06;
  localparam logic [4:0] SLOT_IR_TMO    = 5'h08;
  localparam logic [4:0] SLOT_KBD_SEL   = 5'h0C;
  localparam logic [4:0] SLOT_MIDI_HI   = 5'h12;
  localparam logic [4:0] SLOT_MIDI_LO   = 5'h13;
  localparam logic [4:0] SLOT_MIDI_IRQ  = 5'h15;
  localparam logic [4:0] SLOT_NONE      = 5'h1F;

  logic [7:0] index_r;
  logic       wok;
  logic [3:0] rst_ev;
  logic [7:0] q [NREG];
  logic [NREG-1:0] we;
  logic [7:0] rd_nxt;

  // ----------------------------------------------------------------------
  // Port front end and reset events
  // ----------------------------------------------------------------------
  cfg_port u_port (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .cfg_wr    (cfg_wr),
    .idx_wr    (idx_wr),
    .dat_wr    (dat_wr),
    .wdata     (wdata),
    .index_r   (index_r),
    .in_cfg_r  (in_cfg_r),
    .dat_wr_ok (wok)
  );

  assign rst_ev = {soft_rst_r, sby_por, main_por, hard_rst};

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      soft_rst_r <= 1'b0;
    else
      // A repeat request during the pulse merges into it, so the bit always self-clears
      soft_rst_r <= !soft_rst_r && wok && index_r == cfg_pkg::IDX_CFGCTL
                    && wdata[cfg_pkg::SOFT_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst || (|rst_ev))
      devnum_r <= cfg_pkg::RST_ZERO;
    else if (wok && index_r == cfg_pkg::IDX_DEVNUM)
      devnum_r <= wdata;
  end

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  function automatic logic [4:0] slot(input logic [7:0] ld, input logic [7:0] ix);
    slot = 5'h1F;
    case (ld)
      cfg_pkg::LD_SER1:
        if (ix == cfg_pkg::IDX_IRQ) slot = 5'd0;
        else if (ix == cfg_pkg::IDX_MODE) slot = 5'd1;
      cfg_pkg::LD_SER2:
        if (ix == cfg_pkg::IDX_ENABLE) slot = 5'd2;
        else if (ix == cfg_pkg::IDX_BASE_HI) slot = 5'd3;
        else if (ix == cfg_pkg::IDX_BASE_LO) slot = 5'd4;
        else if (ix == cfg_pkg::IDX_IRQ) slot = 5'd5;
        else if (ix == cfg_pkg::IDX_MODE) slot = 5'd6;
        else if (ix == cfg_pkg::IDX_OPT) slot = 5'd7;
        else if (ix == cfg_pkg::IDX_TIMEOUT) slot = 5'd8;
      cfg_pkg::LD_KBD:
        if (ix == cfg_pkg::IDX_ENABLE) slot = 5'd9;
        else if (ix == cfg_pkg::IDX_IRQ) slot = 5'd10;
        else if (ix == cfg_pkg::IDX_IRQ2) slot = 5'd11;
        else if (ix == cfg_pkg::IDX_MODE) slot = 5'd12;
      cfg_pkg::LD_GAME:
        if (ix == cfg_pkg::IDX_ENABLE) slot = 5'd13;
        else if (ix == cfg_pkg::IDX_BASE_HI) slot = 5'd14;
        else if (ix == cfg_pkg::IDX_BASE_LO) slot = 5'd15;
      cfg_pkg::LD_RUNTIME:
        if (ix == cfg_pkg::IDX_ENABLE) slot = 5'd16;
        else if (ix == cfg_pkg::IDX_MODE) slot = 5'd20;
      cfg_pkg::LD_MIDI:
        if (ix == cfg_pkg::IDX_ENABLE) slot = 5'd17;
        else if (ix == cfg_pkg::IDX_BASE_HI) slot = 5'd18;
        else if (ix == cfg_pkg::IDX_BASE_LO) slot = 5'd19;
        else if (ix == cfg_pkg::IDX_IRQ) slot = 5'd21;
      default:
        slot = 5'h1F;
    endcase
  endfunction

  // Runtime base bytes and the MIDI interrupt select live outside the slot table
  logic [4:0] sel;
  assign sel = slot(devnum_r, index_r);

  always_comb
  begin
    we = '0;
    // Reset wins: a write in a reset event cycle is dropped everywhere except the soft reset bit
    if (wok && !(|rst_ev) && sel < 5'(NREG))
      we[sel] = 1'b1;
  end

  // Per-register reset events and values
  localparam logic [7:0] RV [NREG] = '{cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO,
    cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO,
    cfg_pkg::RST_IR_OPT, cfg_pkg::RST_IR_TMO, cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO,
    cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO,
    cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO, cfg_pkg::RST_ZERO, cfg_pkg::RST_MIDI_HI,
    cfg_pkg::RST_MIDI_LO, cfg_pkg::RST_ZERO};
  localparam logic [3:0] EV [NREG] = '{EV_ALL, EV_HWP, EV_SBY, EV_ALL, EV_ALL, EV_ALL,
    EV_HWP, EV_HWP, EV_HWP, EV_ALL, EV_ALL, EV_ALL, EV_HWP, EV_ALL, EV_ALL, EV_ALL,
    EV_ALL, EV_ALL, EV_ALL, EV_ALL, EV_SBY};

  // Registers with no value for an event keep contents on it
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_reg
      if (g == 12)
      begin : g_kbd
        logic [7:0] lo_r;
        logic [7:0] hi_r;
        // Bits 6:5 survive hard and main resets
        cfg_byte_reg #(.RST_VAL(cfg_pkg::RST_ZERO), .EV_MASK(EV_HWP),
                       .BIT_MASK(~cfg_pkg::KBD_SBY_MASK)) u_lo (
          .sys_clk (sys_clk), .nrst (nrst), .rst_ev (rst_ev), .wr_en (we[g]),
          .wr_data (wdata), .q_r (lo_r));
        cfg_byte_reg #(.RST_VAL(cfg_pkg::RST_ZERO), .EV_MASK(EV_SBY),
                       .BIT_MASK(cfg_pkg::KBD_SBY_MASK)) u_hi (
          .sys_clk (sys_clk), .nrst (nrst), .rst_ev (rst_ev), .wr_en (we[g]),
          .wr_data (wdata), .q_r (hi_r));
        assign q[g] = (lo_r & ~cfg_pkg::KBD_SBY_MASK) | (hi_r & cfg_pkg::KBD_SBY_MASK);
      end
      else
      begin : g_std
        cfg_byte_reg #(.RST_VAL(RV[g]), .EV_MASK(EV[g]), .BIT_MASK(8'hFF)) u_r (
          .sys_clk (sys_clk), .nrst (nrst), .rst_ev (rst_ev), .wr_en (we[g]),
          .wr_data (wdata), .q_r (q[g]));
      end
    end
  endgenerate

  // Midi interrupt select and runtime base sit outside the table array
  logic [7:0] midi_irq_r;
  logic [7:0] rt_base_hi_r;
  logic [7:0] rt_base_lo_r;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || (|rst_ev))
      midi_irq_r <= cfg_pkg::RST_MIDI_IRQ;
    else if (wok && sel == SLOT_MIDI_IRQ)
      midi_irq_r <= wdata;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || (|rst_ev))
      rt_base_hi_r <= cfg_pkg::RST_ZERO;
    else if (wok && devnum_r == cfg_pkg::LD_RUNTIME && index_r == cfg_pkg::IDX_BASE_HI)
      rt_base_hi_r <= wdata;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || (|rst_ev))
      rt_base_lo_r <= cfg_pkg::RST_ZERO;
    else if (wok && devnum_r == cfg_pkg::LD_RUNTIME && index_r == cfg_pkg::IDX_BASE_LO)
      rt_base_lo_r <= wdata;
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_nxt = cfg_pkg::RST_ZERO;
    if (index_r == cfg_pkg::IDX_DEVNUM)
      rd_nxt = devnum_r;
    else if (sel == SLOT_MIDI_IRQ)
      rd_nxt = midi_irq_r;
    else if (devnum_r == cfg_pkg::LD_RUNTIME && index_r == cfg_pkg::IDX_BASE_HI)
      rd_nxt = rt_base_hi_r;
    else if (devnum_r == cfg_pkg::LD_RUNTIME && index_r == cfg_pkg::IDX_BASE_LO)
      rd_nxt = rt_base_lo_r;
    else if (sel < 5'(NREG))
      rd_nxt = q[sel];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rdata_r <= cfg_pkg::RST_ZERO;
    else if (dat_rd && in_cfg_r)
      rdata_r <= rd_nxt;
    else
      rdata_r <= cfg_pkg::RST_ZERO;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ser1_mode_r    <= cfg_pkg::RST_ZERO;
      ser2_mode_r    <= cfg_pkg::RST_ZERO;
      kbd_sel_r      <= cfg_pkg::RST_ZERO;
      midi_base_hi_r <= cfg_pkg::RST_MIDI_HI;
      midi_base_lo_r <= cfg_pkg::RST_MIDI_LO;
    end
    else
    begin
      ser1_mode_r    <= q[SLOT_SER1_MODE];
      ser2_mode_r    <= q[SLOT_SER2_MODE];
      kbd_sel_r      <= q[SLOT_KBD_SEL];
      midi_base_hi_r <= q[SLOT_MIDI_HI];
      midi_base_lo_r <= q[SLOT_MIDI_LO];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  soft_self_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    soft_rst_r |=> !soft_rst_r) else $error("soft reset bit did not clear");
  midi_hi_rst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|rst_ev) |=> q[18] == cfg_pkg::RST_MIDI_HI) else $error("midi base high bad");
  midi_lo_rst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|rst_ev) |=> q[19] == cfg_pkg::RST_MIDI_LO) else $error("midi base low bad");
  kbd_irq_rst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|rst_ev) |=> q[10] == cfg_pkg::RST_ZERO) else $error("kbd irq not cleared");
  ser1_soft_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rst_ev == cfg_pkg::EV_SOFT) |=> $stable(q[1])) else $error("ser1 mode lost");
  ser2_mode_rst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|rst_ev[2:0]) |=> q[6] == cfg_pkg::RST_ZERO) else $error("ser2 mode bad");
  ir_tmo_rst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|rst_ev[2:0]) |=> q[8] == cfg_pkg::RST_IR_TMO) else $error("ir timeout bad");
  kbd_sby_bits_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rst_ev[1:0] != 2'b00 && rst_ev[2] == 1'b0) |=>
    (q[12] & cfg_pkg::KBD_SBY_MASK) == $past(q[12] & cfg_pkg::KBD_SBY_MASK))
    else $error("kbd bits 6:5 changed");
  run_no_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!in_cfg_r && dat_wr && !(|rst_ev)) |=> $stable(devnum_r))
    else $error("write in run state");

  // ----------------------------------------------------------------------
  // Host port sequences and the checks built on them
  // ----------------------------------------------------------------------
  // A set soft reset bit written while no soft reset is running
  sequence soft_req_s;
    wok && index_r == cfg_pkg::IDX_CFGCTL && wdata[cfg_pkg::SOFT_BIT] && !soft_rst_r;
  endsequence
  // Device number written in a cycle free of reset events
  sequence dev_sel_s;
    wok && index_r == cfg_pkg::IDX_DEVNUM && !(|rst_ev);
  endsequence
  // Data port read while the port is open
  sequence cfg_read_s;
    dat_rd && in_cfg_r;
  endsequence

  soft_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    soft_req_s |=> soft_rst_r) else $error("soft reset not raised");
  dev_select_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    dev_sel_s |=> devnum_r == $past(wdata)) else $error("device number not taken");
  rsvd_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_read_s ##0 (sel == SLOT_NONE && index_r != cfg_pkg::IDX_DEVNUM
    && devnum_r != cfg_pkg::LD_RUNTIME) |=> rdata_r == cfg_pkg::RST_ZERO)
    else $error("reserved read not zero");
  run_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (dat_rd && !in_cfg_r) |=> rdata_r == cfg_pkg::RST_ZERO)
    else $error("read in run state");
  cfg_enter_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cfg_wr && wdata == cfg_pkg::KEY_ENTER) |=> in_cfg_r) else $error("enter key ignored");
  cfg_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cfg_wr && wdata == cfg_pkg::KEY_EXIT) |=> !in_cfg_r) else $error("exit key ignored");
  kbd_low_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|rst_ev[2:0]) |=> (q[SLOT_KBD_SEL] & ~cfg_pkg::KBD_SBY_MASK) == cfg_pkg::RST_ZERO)
    else $error("kbd select low bits kept");
  kbd_sby_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rst_ev[2] |=> q[SLOT_KBD_SEL] == cfg_pkg::RST_ZERO) else $error("kbd select kept");
  ser2_soft_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rst_ev == cfg_pkg::EV_SOFT) |=> $stable(q[SLOT_SER2_MODE])) else $error("ser2 mode lost");
  ir_soft_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rst_ev == cfg_pkg::EV_SOFT) |=> $stable(q[SLOT_IR_TMO])) else $error("ir timeout lost");
endmodule

/* File: rtl/cfg_pkg.sv */
// Shared constants for the logical device configuration register bank
package cfg_pkg;
  // Host port values
  localparam logic [7:0] IDX_DEVNUM    = 8'h07;
  localparam logic [7:0] IDX_CFGCTL    = 8'h02;
  localparam logic [7:0] KEY_ENTER     = 8'h55;
  localparam logic [7:0] KEY_EXIT      = 8'hAA;
  localparam int         SOFT_BIT      = 0;
  // Logical device numbers
  localparam logic [7:0] LD_SER1       = 8'h04;
  localparam logic [7:0] LD_SER2       = 8'h05;
  localparam logic [7:0] LD_KBD        = 8'h07;
  localparam logic [7:0] LD_GAME       = 8'h09;
  localparam logic [7:0] LD_RUNTIME    = 8'h0A;
  localparam logic [7:0] LD_MIDI       = 8'h0B;
  // Register indices
  localparam logic [7:0] IDX_ENABLE    = 8'h30;
  localparam logic [7:0] IDX_BASE_HI   = 8'h60;
  localparam logic [7:0] IDX_BASE_LO   = 8'h61;
  localparam logic [7:0] IDX_IRQ       = 8'h70;
  localparam logic [7:0] IDX_IRQ2      = 8'h72;
  localparam logic [7:0] IDX_MODE      = 8'hF0;
  localparam logic [7:0] IDX_OPT       = 8'hF1;
  localparam logic [7:0] IDX_TIMEOUT   = 8'hF2;
  // Reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_MIDI_HI   = 8'h03;
  localparam logic [7:0] RST_MIDI_LO   = 8'h30;
  localparam logic [7:0] RST_MIDI_IRQ  = 8'h05;
  localparam logic [7:0] RST_IR_OPT    = 8'h02;
  localparam logic [7:0] RST_IR_TMO    = 8'h03;
  // Keyboard select bits cleared only by standby reset
  localparam logic [7:0] KBD_SBY_MASK  = 8'h60;
  // Reset event classes, one bit each
  typedef enum logic [3:0] {
    EV_HARD = 4'h1,
    EV_MAIN = 4'h2,
    EV_SBY  = 4'h4,
    EV_SOFT = 4'h8
  } reset_ev_t;
  // Port state
  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_CFG = 2'h2
  } port_state_t;
endpackage

/* File: rtl/cfg_byte_reg.sv */
// One configuration byte with per-event reset loading
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] RST_VAL  = 8'h00,
  parameter logic [3:0] EV_MASK  = 4'hF,
  parameter logic [7:0] BIT_MASK = 8'hFF
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] rst_ev,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q_r
);
  logic hit;
  assign hit = |(rst_ev & EV_MASK);
  // Bits outside the mask keep their value on these events
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      q_r <= RST_VAL;
    else if (hit)
      q_r <= (q_r & ~BIT_MASK) | (RST_VAL & BIT_MASK);
    else if (wr_en)
      q_r <= wr_data;
  end
endmodule

/* File: rtl/cfg_port.sv */
// Index/data configuration port front end with run/config state
`timescale 1ns/1ps
module cfg_port (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       cfg_wr,
  input  wire logic       idx_wr,
  input  wire logic       dat_wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] index_r,
  output logic            in_cfg_r,
  output logic            dat_wr_ok
);
  cfg_pkg::port_state_t state_r;
  cfg_pkg::port_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      cfg_pkg::ST_RUN:
        if (cfg_wr && wdata == cfg_pkg::KEY_ENTER)
          state_nxt = cfg_pkg::ST_CFG;
      cfg_pkg::ST_CFG:
        if (cfg_wr && wdata == cfg_pkg::KEY_EXIT)
          state_nxt = cfg_pkg::ST_RUN;
      default:
        state_nxt = cfg_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      state_r <= cfg_pkg::ST_RUN;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      index_r <= cfg_pkg::RST_ZERO;
    else if (idx_wr && state_r == cfg_pkg::ST_CFG)
      index_r <= wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      in_cfg_r <= 1'b0;
    else
      in_cfg_r <= (state_nxt == cfg_pkg::ST_CFG);
  end

  assign dat_wr_ok = dat_wr && state_r == cfg_pkg::ST_CFG;
endmodule

/* File: tb/tb_logical_device_config_regs.sv */
// Self-checking bench for the logical device configuration register bank
`timescale 1ns/1ps
module tb_logical_device_config_regs;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic [6:0] stb     = 7'h00;
  logic [7:0] wdata   = 8'h00;
  wire logic  hard_rst;
  wire logic  main_por;
  wire logic  sby_por;
  wire logic  cfg_wr;
  wire logic  idx_wr;
  wire logic  dat_wr;
  wire logic  dat_rd;
  logic [7:0] rdata_r;
  logic       in_cfg_r;
  logic [7:0] devnum_r;
  logic       soft_rst_r;
  logic [7:0] ser1_mode_r;
  logic [7:0] ser2_mode_r;
  logic [7:0] kbd_sel_r;
  logic [7:0] midi_base_hi_r;
  logic [7:0] midi_base_lo_r;
  int         n_errors = 0;
  int         compares = 0;
  int         mdl[int];
  int         rw[24]   = '{'h470, 'h4F0, 'h530, 'h560, 'h561, 'h570, 'h5F0, 'h5F1,
                           'h5F2, 'h730, 'h770, 'h772, 'h7F0, 'h930, 'h960, 'h961,
                           'hA30, 'hA60, 'hA61, 'hAF0, 'hB30, 'hB60, 'hB61, 'hB70};
  int         rsv[5]   = '{'h562, 'h563, 'h574, 'hAF1, 'hBF0};
  logic [7:0] q;

  // One-hot strobe vector keeps every request a single assignment per step
  assign {sby_por, main_por, hard_rst, dat_rd, dat_wr, idx_wr, cfg_wr} = stb;

  always #4 sys_clk = ~sys_clk;

  ld_cfg_regs uut (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .hard_rst       (hard_rst),
    .main_por       (main_por),
    .sby_por        (sby_por),
    .cfg_wr         (cfg_wr),
    .idx_wr         (idx_wr),
    .dat_wr         (dat_wr),
    .dat_rd         (dat_rd),
    .wdata          (wdata),
    .rdata_r        (rdata_r),
    .in_cfg_r       (in_cfg_r),
    .devnum_r       (devnum_r),
    .soft_rst_r     (soft_rst_r),
    .ser1_mode_r    (ser1_mode_r),
    .ser2_mode_r    (ser2_mode_r),
    .kbd_sel_r      (kbd_sel_r),
    .midi_base_hi_r (midi_base_hi_r),
    .midi_base_lo_r (midi_base_lo_r)
  );

  // ----------------------------------------------------------------
  // Reference model: -1 means the event leaves the register alone
  // Events: 0 hard, 1 main supply, 2 standby supply, 3 soft
  // ----------------------------------------------------------------
  function automatic int rv(input int a, input int ev);
    case (a)
      'h530, 'hAF0: return (ev == 2) ? 0 : -1;
      'h4F0, 'h5F0: return (ev == 3) ? -1 : 0;
      'h5F1:        return (ev == 3) ? -1 : 'h02;
      'h5F2:        return (ev == 3) ? -1 : 'h03;
      'hB60:        return 'h03;
      'hB61:        return 'h30;
      'hB70:        return 'h05;
      default:      return 0;
    endcase
  endfunction

  task automatic apply(input int ev);
    int a;
    foreach (rw[i])
    begin
      a = rw[i];
      if (a == 'h7F0)
        mdl[a] = (ev == 3) ? mdl[a] : (ev == 2) ? 0 : (mdl[a] & 'h60);
      else if (rv(a, ev) >= 0)
        mdl[a] = rv(a, ev);
    end
  endtask

  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic strobe(input logic [6:0] m, input logic [7:0] v);
    stb   = m;
    wdata = v;
    cyc();
  endtask

  task automatic sel(input int a);
    strobe(7'h02, 8'h07);
    strobe(7'h04, 8'(a >> 8));
    chk(devnum_r, 8'(a >> 8));
    strobe(7'h02, 8'(a));
  endtask

  task automatic wr(input int a, input logic [7:0] v);
    sel(a);
    strobe(7'h04, v);
    if (mdl.exists(a))
      mdl[a] = v;
  endtask

  task automatic rd(input int a, output logic [7:0] r);
    sel(a);
    strobe(7'h08, 8'h00);
    r = rdata_r;
  endtask

  task automatic check_all;
    foreach (rw[i])
    begin
      rd(rw[i], q);
      chk(q, 8'(mdl[rw[i]]));
    end
    foreach (rsv[i])
    begin
      rd(rsv[i], q);
      chk(q, 8'h00);
    end
    stb = 7'h00;
    cyc();
    chk(ser1_mode_r, 8'(mdl['h4F0]));
    chk(ser2_mode_r, 8'(mdl['h5F0]));
    chk(kbd_sel_r, 8'(mdl['h7F0]));
    chk(midi_base_hi_r, 8'(mdl['hB60]));
    chk(midi_base_lo_r, 8'(mdl['hB61]));
  endtask

  task automatic fire(input int ev);
    if (ev == 3)
    begin
      strobe(7'h02, 8'h02);
      strobe(7'h04, 8'h01);
      chk({7'h00, soft_rst_r}, 8'h01);
      strobe(7'h00, 8'h00);
      chk({7'h00, soft_rst_r}, 8'h00);
    end
    else
      strobe(7'h10 << ev, 8'h00);
    strobe(7'h00, 8'h00);
    apply(ev);
    strobe(7'h01, 8'h55);
  endtask

  task automatic fill;
    foreach (rw[i])
      wr(rw[i], 8'($urandom));
    foreach (rsv[i])
      wr(rsv[i], 8'($urandom));
  endtask

  task automatic close_out;
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(46524));
    foreach (rw[i])
      mdl[rw[i]] = 0;
    apply(2);
    repeat (6) cyc();
    nrst = 1'b1;
    chk({7'h00, in_cfg_r}, 8'h00);
    strobe(7'h01, 8'h55);
    chk({7'h00, in_cfg_r}, 8'h01);
    check_all();
    for (int ev = 0; ev < 4; ev++)
    begin
      fill();
      check_all();
      fire(ev);
      check_all();
    end
    // Writes outside configuration state must not land anywhere
    // A known non-zero byte under the index makes a leaking run-state read visible
    fill();
    wr('hB70, 8'hA5);
    strobe(7'h01, 8'hAA);
    chk({7'h00, in_cfg_r}, 8'h00);
    strobe(7'h02, 8'h07);
    strobe(7'h04, 8'h0B);
    strobe(7'h02, 8'h70);
    strobe(7'h04, 8'h5A);
    strobe(7'h08, 8'h00);
    chk(rdata_r, 8'h00);
    strobe(7'h01, 8'h55);
    check_all();
    // Mid-run bus reset returns every register to its default
    fill();
    stb  = 7'h00;
    nrst = 1'b0;
    cyc();
    nrst = 1'b1;
    apply(2);
    strobe(7'h01, 8'h55);
    check_all();
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end
endmodule
